// ---- src/rcc_pkg.sv ----
// Package of constants for the reset chip configuration block
package rcc_pkg;
  // Register byte addresses (word aligned)
  localparam logic [7:0] RCC_OFF_CHIPCFG = 8'h04;
  localparam logic [7:0] RCC_OFF_RSTCFG = 8'h08;
  localparam logic [7:0] RCC_OFF_IDENT = 8'h0C;
  localparam logic [7:0] RCC_OFF_EXTCFG = 8'h10;
  localparam logic [7:0] RCC_OFF_STATUS = 8'h14;
  localparam logic [7:0] RCC_OFF_DEBUG = 8'h18;
  // Identity layout
  localparam int RCC_ID_PART_LSB = 6;
  localparam int RCC_ID_PART_W = 10;
  localparam int RCC_ID_REV_W = 6;
  // Extended configuration fields
  localparam int RCC_EXT_RATIO_BIT = 15;
  localparam logic [15:0] RCC_EXT_RESET = 16'h0000;
  // Reset configuration defaults
  localparam int RCC_RST_LOAD_BIT = 5;
  localparam int RCC_RST_MODE_BIT = 0;
  localparam logic [15:0] RCC_RST_RESET = 16'h0000;
  // Chip configuration register fields
  localparam int RCC_CHIP_LOAD_BIT = 15;
  localparam int RCC_CHIP_MODE_LSB = 8;
  localparam logic [2:0] RCC_MODE_SINGLE = 3'h6;
  localparam logic [2:0] RCC_MODE_SERIAL = 3'h5;
  // Override data pin positions
  localparam int RCC_PIN_MODE_BIT = 0;
  localparam int RCC_PIN_LOAD_BIT = 5;
  localparam int RCC_PIN_CLK_LSB = 1;
  localparam int RCC_CLK_W = 3;
  localparam logic [2:0] RCC_CLK_DEFAULT = 3'h0;
  localparam int RCC_PIN_MOD_LSB = 8;
  localparam int RCC_MOD_W = 8;
  // AXI responses
  localparam logic [1:0] RCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCC_RESP_SLVERR = 2'h2;
endpackage

// ---- src/rcc_top.sv ----
// Reset chip configuration block with AXI4-Lite register slave
// How it works
// - Identity bits 15..6 hold part code
// - Identity bits 5..0 hold mask revision
// - Extended bit 15: 0 half, 1 full ratio
// - Extended register takes only first write outside debug
// - Override pins defined immediately during reset
// - Select pin pulled up in reset, then reassigned
// - Select high in reset: defaults, pins ignored
// - Select low in reset: capture data pins
// - No override: outputs follow reset defaults
// - Defaults change only through asserted select
// - Pad drive fixed at reset, default bit 5
// - Clock and chip mode fixed at reset
// - Reset sets every register to startup value
// - Write-once bits readable; debug writes keep writable
// - Extended register resets to zero, half ratio
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module rcc_top
  import rcc_pkg::*;
#(
  parameter logic [9:0] PART_CODE = 10'h155, // Arbitrary neutral value
  parameter logic [5:0] MASK_REV = 6'h00,
  parameter int DATA_PINS_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_config_select_n,
  input wire logic [DATA_PINS_W-1:0] data_pins_in,
  input wire logic debug_mode,
  output logic select_pin_pullup_en,
  output logic select_pin_alt_func,
  output logic pad_full_drive,
  output logic [2:0] chip_mode,
  output logic [RCC_CLK_W-1:0] clock_mode,
  output logic [RCC_MOD_W-1:0] module_config,
  output logic narrow_bus_ratio_select
);

  // Refused at elaboration: override fields must fit the pin bus
  if (DATA_PINS_W < RCC_PIN_MOD_LSB + RCC_MOD_W) begin : g_pins_chk
    $error("DATA_PINS_W too small for override fields");
  end

  // Pins from the board pass two flops first
  logic sel_s1_r, sel_s2_r;
  logic [DATA_PINS_W-1:0] pins_s1_r, pins_s2_r;
  always_ff @(posedge aclk) begin
    sel_s1_r <= reset_config_select_n;
    sel_s2_r <= sel_s1_r;
    pins_s1_r <= data_pins_in;
    pins_s2_r <= pins_s1_r;
  end

  // Configuration state: captured while reset holds, frozen after
  logic pad_r, pad_nxt, mode_r, mode_nxt, ovr_r, ovr_nxt;
  logic [RCC_CLK_W-1:0] clk_r, clk_nxt;
  logic [RCC_MOD_W-1:0] mod_r, mod_nxt;
  logic pull_r, pull_nxt, alt_r, alt_nxt;
  logic [2:0] cmode_r, cmode_nxt;
  logic [15:0] rst_cfg_r;

  always_comb begin
    pad_nxt = pad_r;
    mode_nxt = mode_r;
    clk_nxt = clk_r;
    mod_nxt = mod_r;
    ovr_nxt = ovr_r;
    cmode_nxt = cmode_r;
    pull_nxt = 1'b0;
    alt_nxt = 1'b1;
    if (!aresetn) begin
      pull_nxt = 1'b1;
      alt_nxt = 1'b0;
      if (!sel_s2_r) begin
        ovr_nxt = 1'b1;
        pad_nxt = pins_s2_r[RCC_PIN_LOAD_BIT];
        mode_nxt = pins_s2_r[RCC_PIN_MODE_BIT];
        clk_nxt = pins_s2_r[RCC_PIN_CLK_LSB +: RCC_CLK_W];
        mod_nxt = pins_s2_r[RCC_PIN_MOD_LSB +: RCC_MOD_W];
      end else begin
        ovr_nxt = 1'b0;
        pad_nxt = rst_cfg_r[RCC_RST_LOAD_BIT];
        mode_nxt = rst_cfg_r[RCC_RST_MODE_BIT];
        clk_nxt = RCC_CLK_DEFAULT;
        mod_nxt = '0;
      end
      // Decoded once here so the mode pins come straight from a flop
      cmode_nxt = mode_nxt ? RCC_MODE_SINGLE : RCC_MODE_SERIAL;
    end
  end

  // Defaults register is read-only; outside reset nothing changes config
  always_ff @(posedge aclk) begin
    rst_cfg_r <= RCC_RST_RESET;
    pad_r <= pad_nxt;
    mode_r <= mode_nxt;
    clk_r <= clk_nxt;
    mod_r <= mod_nxt;
    ovr_r <= ovr_nxt;
    cmode_r <= cmode_nxt;
    pull_r <= pull_nxt;
    alt_r <= alt_nxt;
  end

  // Extended register, write-once outside debug
  logic [15:0] ext_r, ext_nxt;
  logic locked_r, locked_nxt;
  logic dbg_s1_r, dbg_s2_r;
  always_ff @(posedge aclk) begin
    dbg_s1_r <= debug_mode;
    dbg_s2_r <= dbg_s1_r;
  end

  // Write channel
  typedef enum logic [1:0] {
    RCC_WR_IDLE = 2'b00,
    RCC_WR_RESP = 2'b01
  } rcc_wr_t;
  rcc_wr_t wst_r, wst_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic bvalid_r, bvalid_nxt, awready_r, awready_nxt, wready_r, wready_nxt;

  function automatic logic rcc_mapped(input logic [7:0] a);
    return a == RCC_OFF_CHIPCFG || a == RCC_OFF_RSTCFG || a == RCC_OFF_IDENT ||
           a == RCC_OFF_EXTCFG || a == RCC_OFF_STATUS || a == RCC_OFF_DEBUG;
  endfunction

  always_comb begin
    wst_nxt = wst_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bresp_nxt = bresp_r;
    bvalid_nxt = bvalid_r;
    ext_nxt = ext_r;
    locked_nxt = locked_r;
    awready_nxt = 1'b0;
    wready_nxt = 1'b0;
    unique case (wst_r)
      RCC_WR_IDLE: begin
        if (s_axi_awvalid && awready_r) begin
          aw_held_nxt = 1'b1;
          awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
          w_held_nxt = 1'b1;
          wdata_nxt = s_axi_wdata;
          wstrb_nxt = s_axi_wstrb;
        end
        if (aw_held_r && w_held_r) begin
          aw_held_nxt = 1'b0;
          w_held_nxt = 1'b0;
          bvalid_nxt = 1'b1;
          wst_nxt = RCC_WR_RESP;
          bresp_nxt = rcc_mapped(awaddr_r) ? RCC_RESP_OKAY : RCC_RESP_SLVERR;
          if (awaddr_r == RCC_OFF_EXTCFG && wstrb_r[1:0] != 2'b00) begin
            if (!locked_r || dbg_s2_r) begin
              for (int i = 0; i < 2; i++) begin
                if (wstrb_r[i]) ext_nxt[i*8 +: 8] = wdata_r[i*8 +: 8];
              end
              locked_nxt = !dbg_s2_r;
            end
          end
        end else begin
          awready_nxt = !aw_held_nxt && !(s_axi_awvalid && awready_r);
          wready_nxt = !w_held_nxt && !(s_axi_wvalid && wready_r);
        end
      end
      RCC_WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_nxt = 1'b0;
          wst_nxt = RCC_WR_IDLE;
          awready_nxt = 1'b1;
          wready_nxt = 1'b1;
        end
      end
      default: wst_nxt = RCC_WR_IDLE;
    endcase
    if (!aresetn) begin
      wst_nxt = RCC_WR_IDLE;
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      awaddr_nxt = '0;
      wdata_nxt = '0;
      wstrb_nxt = '0;
      bresp_nxt = RCC_RESP_OKAY;
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b0;
      wready_nxt = 1'b0;
      ext_nxt = RCC_EXT_RESET;
      locked_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    wst_r <= wst_nxt;
    aw_held_r <= aw_held_nxt;
    w_held_r <= w_held_nxt;
    awaddr_r <= awaddr_nxt;
    wdata_r <= wdata_nxt;
    wstrb_r <= wstrb_nxt;
    bresp_r <= bresp_nxt;
    bvalid_r <= bvalid_nxt;
    awready_r <= awready_nxt;
    wready_r <= wready_nxt;
    ext_r <= ext_nxt;
    locked_r <= locked_nxt;
  end

  // Read channel; one read in flight
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic rvalid_r, rvalid_nxt, arready_r, arready_nxt;
  logic [15:0] chip_word, ident_word;

  always_comb begin
    chip_word = '0;
    chip_word[RCC_CHIP_LOAD_BIT] = pad_r;
    chip_word[RCC_CHIP_MODE_LSB +: 3] = cmode_r;
    ident_word = {PART_CODE, MASK_REV};
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    rvalid_nxt = rvalid_r;
    arready_nxt = arready_r;
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = RCC_RESP_OKAY;
      unique case (s_axi_araddr)
        RCC_OFF_CHIPCFG: rdata_nxt = {16'h0000, chip_word};
        RCC_OFF_RSTCFG: rdata_nxt = {16'h0000, rst_cfg_r};
        RCC_OFF_IDENT: rdata_nxt = {16'h0000, ident_word};
        RCC_OFF_EXTCFG: rdata_nxt = {16'h0000, ext_r};
        RCC_OFF_STATUS: rdata_nxt = {29'h0, dbg_s2_r, locked_r, ovr_r};
        RCC_OFF_DEBUG: rdata_nxt = {{(32-RCC_MOD_W-RCC_CLK_W){1'b0}}, mod_r, clk_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RCC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    if (!aresetn) begin
      rdata_nxt = '0;
      rresp_nxt = RCC_RESP_OKAY;
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    rdata_r <= rdata_nxt;
    rresp_r <= rresp_nxt;
    rvalid_r <= rvalid_nxt;
    arready_r <= arready_nxt;
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign select_pin_pullup_en = pull_r;
  assign select_pin_alt_func = alt_r;
  assign pad_full_drive = pad_r;
  assign chip_mode = cmode_r;
  assign clock_mode = clk_r;
  assign module_config = mod_r;
  assign narrow_bus_ratio_select = ext_r[RCC_EXT_RATIO_BIT];

  // Checks
  pull_in_reset_a: assert property (@(posedge aclk) !aresetn |=> pull_r && !alt_r)
    else $error("select pin not pulled up in reset");
  alt_after_a: assert property (@(posedge aclk) aresetn ##1 aresetn |-> alt_r && !pull_r)
    else $error("select pin not reassigned");
  cfg_frozen_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && $past(aresetn) |-> $stable(pad_r) && $stable(clk_r) && $stable(mode_r))
    else $error("config changed outside reset");
  default_path_a: assert property (@(posedge aclk) !aresetn && sel_s2_r |=> !ovr_r && !pad_r)
    else $error("default path wrong");
  override_path_a: assert property (@(posedge aclk)
    !aresetn && !sel_s2_r |=> ovr_r && pad_r == $past(pins_s2_r[RCC_PIN_LOAD_BIT]))
    else $error("override not captured");
  ext_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    locked_r && !dbg_s2_r |=> $stable(ext_r))
    else $error("locked register changed");
  ext_reset_a: assert property (@(posedge aclk) !aresetn |=> ext_r == RCC_EXT_RESET)
    else $error("extended reset wrong");
  ident_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && arready_r && s_axi_araddr == RCC_OFF_IDENT
    |=> rdata_r[15:0] == {PART_CODE, MASK_REV})
    else $error("identity read wrong");
  resp_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_held_r && w_held_r && wst_r == RCC_WR_IDLE |=> bvalid_r)
    else $error("write response late");
  write_cov: cover property (@(posedge aclk) bvalid_r && s_axi_bready);
  read_cov: cover property (@(posedge aclk) rvalid_r && s_axi_rready);
  ovr_cov: cover property (@(posedge aclk) aresetn && ovr_r);
  lock_cov: cover property (@(posedge aclk) locked_r);
endmodule

// ---- tb/rcc_board.sv ----
// Board model driving reset override levels onto the data and select pins
`timescale 1ns/1ps
module rcc_board (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic drive_ovr,
  input wire logic [15:0] level,
  input wire logic pullup_en,
  output logic select_n,
  output logic [15:0] pins
);
  logic sel_drv;
  initial begin
    sel_drv = 1'b0;
    pins = 16'h0000;
  end
  // Levels held only in reset; released bus wanders so stale values never help
  always @(posedge aclk) begin
    if (!aresetn) begin
      pins <= level;
      sel_drv <= drive_ovr;
    end else begin
      pins <= ~pins;
      sel_drv <= 1'b0;
    end
  end
  // Weak pull-up only while the device enables it
  assign select_n = sel_drv ? 1'b0 : (pullup_en ? 1'b1 : pins[0]);
endmodule

// ---- tb/reset_chip_configuration_bench.sv ----
// Self-checking bench for the reset chip configuration block
`timescale 1ns/1ps
module reset_chip_configuration_bench;
  import rcc_pkg::*;
  localparam logic [9:0] PCODE = 10'h2A6; // Arbitrary value
  localparam logic [5:0] PREV = 6'h03;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, dbg = 0, ovr = 0;
  logic awready, wready, bvalid, arready, rvalid, sel_n, pu, alt, pad, narrow;
  logic [1:0] bresp, rresp;
  logic [15:0] level = 16'h0, pins;
  logic [2:0] cmode, clk;
  logic [7:0] modc;
  int n_fail = 0, total_checks = 0, seed = 85;
  always #5 aclk = ~aclk;

  rcc_board u_board (.aclk(aclk), .aresetn(aresetn), .drive_ovr(ovr), .level(level),
    .pullup_en(pu), .select_n(sel_n), .pins(pins));
  rcc_top #(.PART_CODE(PCODE), .MASK_REV(PREV), .DATA_PINS_W(16)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .reset_config_select_n(sel_n), .data_pins_in(pins), .debug_mode(dbg),
    .select_pin_pullup_en(pu), .select_pin_alt_func(alt), .pad_full_drive(pad),
    .chip_mode(cmode), .clock_mode(clk), .module_config(modc),
    .narrow_bus_ratio_select(narrow));

  task conclude;
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task tmo;
    n_fail++;
    $display("mismatch at %0t: bus wait ran out", $time);
    conclude();
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    bit ta, td;
    ta = 0;
    td = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40 && !(ta && td); i++) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        td = 1;
        wvalid <= 1'b0;
      end
    end
    if (!(ta && td)) tmo();
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (bvalid) break;
    end
    if (i == 40) tmo();
    r = bresp;
    bready <= 1'b0;
    // One edge between transfers so bready is never set twice in a step
    @(posedge aclk);
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) break;
    end
    if (i == 40) tmo();
    arvalid <= 1'b0;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (rvalid) break;
    end
    if (i == 40) tmo();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, e, "read data");
    chk({30'h0, r}, {30'h0, er}, "read response");
  endtask
  task wrc(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk({30'h0, r}, {30'h0, RCC_RESP_OKAY}, "write response");
  endtask
  function automatic logic [14:0] exp_cfg(input logic o, input logic [15:0] p);
    if (!o) return {RCC_RST_RESET[RCC_RST_LOAD_BIT],
      RCC_RST_RESET[RCC_RST_MODE_BIT] ? RCC_MODE_SINGLE : RCC_MODE_SERIAL, RCC_CLK_DEFAULT, 8'h00};
    return {p[5], p[0] ? RCC_MODE_SINGLE : RCC_MODE_SERIAL, p[3:1], p[15:8]};
  endfunction
  task do_reset(input logic o, input logic [15:0] p);
    logic [14:0] e;
    e = exp_cfg(o, p);
    aresetn <= 1'b0;
    ovr <= o;
    level <= p;
    repeat (6) @(posedge aclk);
    chk({31'h0, pu}, 32'h1, "pull-up in reset");
    chk({31'h0, alt}, 32'h0, "pin function in reset");
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({31'h0, alt}, 32'h1, "pin function after reset");
    chk({17'h0, pad, cmode, clk, modc}, {17'h0, e}, "config");
    rdc(RCC_OFF_CHIPCFG, {16'h0, e[14], 4'h0, e[13:11], 8'h00}, RCC_RESP_OKAY);
    rdc(RCC_OFF_EXTCFG, 32'h0, RCC_RESP_OKAY);
    rdc(RCC_OFF_STATUS, {29'h0, 2'b00, o}, RCC_RESP_OKAY);
    rdc(RCC_OFF_DEBUG, {21'h0, e[7:0], e[10:8]}, RCC_RESP_OKAY);
    chk({31'h0, narrow}, 32'h0, "ratio after reset");
  endtask

  initial begin
    logic [31:0] rv;
    int k;
    do_reset(1'b0, 16'hFFFF);
    rdc(RCC_OFF_IDENT, {16'h0, PCODE, PREV}, RCC_RESP_OKAY);
    rdc(RCC_OFF_RSTCFG, {16'h0, RCC_RST_RESET}, RCC_RESP_OKAY);
    wrc(RCC_OFF_IDENT, 32'h0000FFFF);
    rdc(RCC_OFF_IDENT, {16'h0, PCODE, PREV}, RCC_RESP_OKAY);
    rdc(8'h40, 32'h0, RCC_RESP_SLVERR);
    wrc(RCC_OFF_EXTCFG, 32'h00008000);
    chk({31'h0, narrow}, 32'h1, "ratio full");
    wrc(RCC_OFF_EXTCFG, 32'h0);
    rdc(RCC_OFF_EXTCFG, 32'h00008000, RCC_RESP_OKAY);
    chk({31'h0, narrow}, 32'h1, "second write ignored");
    for (k = 0; k < 5; k++) begin
      rv = $random(seed);
      do_reset(k[0], rv[15:0]);
    end
    wrc(RCC_OFF_EXTCFG, 32'h0);
    wrc(RCC_OFF_EXTCFG, 32'h00008000);
    chk({31'h0, narrow}, 32'h0, "locked at half ratio");
    do_reset(1'b1, 16'h0000);
    dbg <= 1'b1;
    repeat (4) @(posedge aclk);
    wrc(RCC_OFF_EXTCFG, 32'h00008000);
    wrc(RCC_OFF_EXTCFG, 32'h0);
    rdc(RCC_OFF_EXTCFG, 32'h0, RCC_RESP_OKAY);
    rdc(RCC_OFF_STATUS, 32'h5, RCC_RESP_OKAY);
    dbg <= 1'b0;
    repeat (4) @(posedge aclk);
    wrc(RCC_OFF_EXTCFG, 32'h00008000);
    chk({31'h0, narrow}, 32'h1, "writable after debug");
    wrc(RCC_OFF_EXTCFG, 32'h0);
    rdc(RCC_OFF_EXTCFG, 32'h00008000, RCC_RESP_OKAY);
    rdc(RCC_OFF_STATUS, 32'h3, RCC_RESP_OKAY);
    conclude();
  end
endmodule
